// *** design/pcu_bank.sv ***
// file: the register bank and access checker
// assumes one coprocessor request per valid cycle from the core, answered next cycle
`timescale 1ns/10ps
`include "pcu_params.svh"
module pcu_bank #(
   parameter logic [1:0] CHAN_IMPL = 2'h3
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              sys_rst,
   // core access port
   input  wire pcu_pkg::pcu_req_s req,
   input  wire logic              nonsecure_engine_access_bit,
   output pcu_pkg::pcu_rsp_s      rsp,
   // channel state from the engine
   input  wire logic [1:0]        chan_running,
   input  wire logic [1:0]        chan_interrupt,
   // control toward the engine
   output logic [1:0]             chan_user_permit,
   output logic                   channel_select,
   output logic                   chan_access_ok
);
   // registered state, each with its next value
   pcu_pkg::pcu_rsp_s rsp_r;
   pcu_pkg::pcu_rsp_s rsp_nxt;
   logic [1:0]        permit_r;
   logic [1:0]        permit_nxt;
   logic              select_r;
   logic              select_nxt;
   logic              ok_r;
   logic              ok_nxt;
   logic [1:0]        chan_func_r;
   logic [1:0]        chan_func_nxt;

   // request decode, shared by every state group
   pcu_pkg::pcu_grp_e grp;
   logic              taken;
   logic              is_select;
   logic              priv_ok;
   logic              ns_blocked;
   logic              sel_permit;
   logic              any_permit;
   logic              id_deny;
   logic              permit_deny;
   logic              select_deny;
   logic              chan_deny;
   logic              permit_wr;
   logic              select_wr;
   logic              chan_pass;

   // crn picks the engine space, crm the register group inside it
   function automatic pcu_pkg::pcu_grp_e grp_of(input logic [3:0] crn, input logic [3:0] crm);
      if (crn != `PCU_CRN_ENGINE)
         grp_of = pcu_pkg::PCU_GRP_NONE;
      else if (crm == `PCU_CRM_ID_STATUS)
         grp_of = pcu_pkg::PCU_GRP_ID;
      else if (crm == `PCU_CRM_USER_PERMIT)
         grp_of = pcu_pkg::PCU_GRP_PERMIT;
      else
         grp_of = pcu_pkg::PCU_GRP_CHAN;
   endfunction

   // one view per selector; running and interrupt bits hide an absent channel except in the first cycle after reset
   function automatic logic [31:0] view_of(input logic [2:0] sel, input logic [1:0] func,
                                           input logic [1:0] run, input logic [1:0] irq);
      case (sel)
         `PCU_OPC2_PRESENT:   view_of = {30'h0, func};
         `PCU_OPC2_RUNNING:   view_of = {30'h0, run & func};
         `PCU_OPC2_INTERRUPT: view_of = {30'h0, irq & func};
         // selector 1 is reserved: it reads zero rather than trapping
         default:             view_of = 32'h0;
      endcase
   endfunction

   // every denial is decided once here, so the answer and the state updates agree
   always_comb begin
      grp         = grp_of(req.crn, req.crm);
      taken       = req.valid && grp != pcu_pkg::PCU_GRP_NONE;
      is_select   = req.crm == `PCU_CRM_CHAN_SELECT;
      // secure privileged always passes; nonsecure privileged needs the access bit
      priv_ok     = !req.user_mode &&
                    (!req.nonsecure || nonsecure_engine_access_bit);
      ns_blocked  = req.nonsecure && !nonsecure_engine_access_bit;
      sel_permit  = permit_r[select_r];
      any_permit  = |permit_r;
      id_deny     = !priv_ok || req.write || req.opc2 > `PCU_OPC2_INTERRUPT;
      permit_deny = !priv_ok;
      // channel registers need the access bit when nonsecure, even in privileged mode
      select_deny = ns_blocked || (req.user_mode && !any_permit);
      chan_deny   = ns_blocked || (req.user_mode && !sel_permit);
      permit_wr   = taken && grp == pcu_pkg::PCU_GRP_PERMIT && req.write && !permit_deny;
      select_wr   = taken && grp == pcu_pkg::PCU_GRP_CHAN && is_select &&
                    req.write && !select_deny;
      chan_pass   = taken && grp == pcu_pkg::PCU_GRP_CHAN && !is_select && !chan_deny;
   end

   // function bits read as enabled out of reset, then settle to the built channels
   always_comb begin
      chan_func_nxt = CHAN_IMPL;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         chan_func_r <= `PCU_CHAN_FUNC_RESET;
      end else begin
         chan_func_r <= chan_func_nxt;
      end
   end

   // traps and writes answer with zero data
   always_comb begin
      rsp_nxt = '0;
      // other crn values are not ours and get no answer at all
      if (taken) begin
         rsp_nxt.done = 1'b1;
         case (grp)
            pcu_pkg::PCU_GRP_ID: begin
               rsp_nxt.undef = id_deny;
               if (!id_deny) begin
                  rsp_nxt.rdata = view_of(req.opc2, chan_func_r,
                                          chan_running, chan_interrupt);
               end
            end
            pcu_pkg::PCU_GRP_PERMIT: begin
               rsp_nxt.undef = permit_deny;
               if (!permit_deny && !req.write) begin
                  rsp_nxt.rdata = {30'h0, permit_r};
               end
            end
            default: begin
               if (is_select) begin
                  rsp_nxt.undef = select_deny;
                  if (!select_deny && !req.write) begin
                     rsp_nxt.rdata = {31'h0, select_r};
                  end
               end else begin
                  rsp_nxt.undef = chan_deny;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rsp_r <= '0;
      end else begin
         rsp_r <= rsp_nxt;
      end
   end

   // permission writes keep only the two channel bits
   always_comb begin
      permit_nxt = permit_r;
      if (permit_wr) begin
         permit_nxt = req.wdata[1:0];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         permit_r <= `PCU_PERMIT_RESET;
      end else begin
         permit_r <= permit_nxt;
      end
   end

   // a denied select write leaves the selected channel alone
   always_comb begin
      select_nxt = select_r;
      if (select_wr) begin
         select_nxt = req.wdata[0];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         select_r <= `PCU_SELECT_RESET;
      end else begin
         select_r <= select_nxt;
      end
   end

   // one pulse per passed per-channel access; the engine does the work
   always_comb begin
      ok_nxt = chan_pass;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ok_r <= 1'b0;
      end else begin
         ok_r <= ok_nxt;
      end
   end

   // every output comes straight from its register
   assign rsp              = rsp_r;
   assign chan_user_permit = permit_r;
   assign channel_select   = select_r;
   assign chan_access_ok   = ok_r;
endmodule // pcu_bank

// *** design/pcu_params.svh ***
// constants for the preload channel id and user access register bank
// assumes a coprocessor access port decoded by crn/crm/opc2 from the core
`ifndef PCU_PARAMS_SVH
`define PCU_PARAMS_SVH
`define PCU_CRN_ENGINE      4'hb
`define PCU_CRM_ID_STATUS   4'h0
`define PCU_CRM_USER_PERMIT 4'h1
`define PCU_CRM_CHAN_SELECT 4'h2
`define PCU_CRM_ENABLE_CMD  4'h3
`define PCU_CRM_CONTROL     4'h4
`define PCU_CRM_START_ADDR  4'h5
`define PCU_CRM_END_ADDR    4'h7
`define PCU_CRM_CHAN_STATUS 4'h8
`define PCU_OPC2_PRESENT    3'h0
`define PCU_OPC2_RESERVED   3'h1
`define PCU_OPC2_RUNNING    3'h2
`define PCU_OPC2_INTERRUPT  3'h3
`define PCU_CHAN_FUNC_RESET 2'h3
`define PCU_PERMIT_RESET    2'h0
`define PCU_SELECT_RESET    1'h0
`endif

// *** design/pcu_pkg.sv ***
// types for the preload channel id and user access register bank
// assumes pcu_params.svh supplies the numeric constants
package pcu_pkg;
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        user_mode;
      logic        nonsecure;
      logic [3:0]  crn;
      logic [3:0]  crm;
      logic [2:0]  opc2;
      logic [31:0] wdata;
   } pcu_req_s;
   typedef struct packed {
      logic        done;
      logic        undef;
      logic [31:0] rdata;
   } pcu_rsp_s;
   typedef enum logic [1:0] {PCU_GRP_NONE, PCU_GRP_ID, PCU_GRP_PERMIT, PCU_GRP_CHAN} pcu_grp_e;
endpackage

// *** verif/pcu_bank_checker.sv ***
// checker for the register bank access rules
// assumes bind onto the pcu_bank ports
`timescale 1ns/10ps
module pcu_bank_checker (
   // watched ports
   input wire logic              mclk,
   input wire logic              sys_rst,
   input wire pcu_pkg::pcu_req_s req,
   input wire logic              nonsecure_engine_access_bit,
   input wire pcu_pkg::pcu_rsp_s rsp,
   input wire logic [1:0]        chan_running,
   input wire logic [1:0]        chan_user_permit,
   input wire logic              channel_select,
   input wire logic              chan_access_ok
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic hit;
   logic id;
   logic sp;
   logic nsd;
   assign hit = req.valid && req.crn == 4'hb;
   assign id = hit && req.crm == 4'h0;
   assign sp = !req.user_mode && !req.nonsecure && !req.write;
   assign nsd = req.nonsecure && !nonsecure_engine_access_bit;
   a_answer_next: assert property (hit |=> rsp.done) else $error("no answer");
   a_view_high: assert property (id && req.opc2[2] |=> rsp.undef) else $error("view trap");
   a_view_reserved: assert property (id && sp && req.opc2 == 3'h1 |=> !rsp.undef)
      else $error("reserved view trapped");
   a_view_running: assert property (id && sp && req.opc2 == 3'h2
      |=> rsp.rdata == {30'h0, $past(chan_running)}) else $error("running view");
   a_id_guard: assert property (id && (req.write || req.user_mode || nsd) |=> rsp.undef)
      else $error("id guard");
   a_permit_guard: assert property (hit && req.crm == 4'h1 && (req.user_mode || nsd)
      |=> rsp.undef && $stable(chan_user_permit)) else $error("permit guard");
   a_chan_trap: assert property (hit && req.user_mode && req.crm > 4'h2
      && !chan_user_permit[channel_select] |=> rsp.undef) else $error("chan trap");
   a_select_user: assert property (hit && req.user_mode && !req.nonsecure
      && req.crm == 4'h2 && |chan_user_permit |=> !rsp.undef) else $error("select");
   a_permit_write: assert property (hit && req.crm == 4'h1 && req.write && !req.user_mode
      && !req.nonsecure |=> chan_user_permit == $past(req.wdata[1:0]))
      else $error("permit write");
   a_chan_pass: assert property (hit && req.crm > 4'h2 && !req.user_mode && !nsd
      |=> chan_access_ok) else $error("chan pass");
endmodule // pcu_bank_checker
bind pcu_bank pcu_bank_checker u_chk (.mclk(mclk), .sys_rst(sys_rst), .req(req),
   .nonsecure_engine_access_bit(nonsecure_engine_access_bit), .rsp(rsp),
   .chan_running(chan_running), .chan_user_permit(chan_user_permit),
   .channel_select(channel_select), .chan_access_ok(chan_access_ok));

// *** verif/pcu_bank_tb.sv ***
// self-checking bench for the register bank
// assumes pcu_bank, pcu_engine_model and the bound checker
`timescale 1ns/10ps
module pcu_bank_tb;
   localparam logic [2:0] SR = 3'h0, SW = 3'h4, NR = 3'h1, NW = 3'h5, UW = 3'h6, UR = 3'h2;
   localparam logic [2:0] NU = 3'h3, NUW = 3'h7;
   logic              mclk;
   logic              sys_rst;
   logic              nsab;
   logic [3:0]        lvl_set;
   logic [3:0]        lvl;
   logic [1:0]        permit_w;
   logic              sel_w;
   logic              ok_w;
   pcu_pkg::pcu_req_s req;
   pcu_pkg::pcu_rsp_s rsp;
   int                num_errors = 0;
   int                checks = 0;
   pcu_bank dut (.mclk(mclk), .sys_rst(sys_rst), .req(req), .nonsecure_engine_access_bit(nsab),
      .rsp(rsp), .chan_running(lvl[1:0]), .chan_interrupt(lvl[3:2]),
      .chan_user_permit(permit_w), .channel_select(sel_w), .chan_access_ok(ok_w));
   pcu_engine_model eng (.mclk(mclk), .lvl_set(lvl_set), .lvl(lvl));
   task chk(input string n, input logic [31:0] x, input logic [31:0] s);
      checks++;
      if (x !== s) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", n, x, s);
      end
   endtask
   // m is {write, user, nonsecure}; traps and writes return zero data
   task acc(input logic [2:0] m, input logic [3:0] crm, input logic [2:0] op,
      input logic [31:0] d, input logic xu);
      @(posedge mclk);
      req <= '{1'b1, m[2], m[1], m[0], 4'hb, crm, op, d};
      @(posedge mclk);
      req.valid <= 1'b0;
      #1;
      chk("done_undef", {30'h0, xu, 1'b1}, {30'h0, rsp.undef, rsp.done});
      chk("rdata", (m[2] || xu) ? 32'h0 : d, rsp.rdata);
   endtask
   task summarize;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      req = '0;
      nsab = 1'b0;
      lvl_set = 4'h9;
      sys_rst = 1'b1;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      chk("reset", 32'h0, {29'h0, permit_w, sel_w});
      acc(SR, 4'h0, 3'h0, 32'h3, 1'b0);
      acc(SR, 4'h0, 3'h2, 32'h1, 1'b0);
      acc(SR, 4'h0, 3'h3, 32'h2, 1'b0);
      acc(SR, 4'h0, 3'h1, 32'h0, 1'b0);
      for (int i = 4; i < 8; i++) acc(SR, 4'h0, 3'(i), 32'h0, 1'b1);
      acc(SW, 4'h0, 3'h0, 32'h0, 1'b1);
      acc(NR, 4'h0, 3'h0, 32'h0, 1'b1);
      acc(UR, 4'h0, 3'h0, 32'h0, 1'b1);
      acc(UW, 4'h4, 3'h0, 32'h5, 1'b1);
      acc(UW, 4'h2, 3'h0, 32'h1, 1'b1);
      $display("test id views done");
      acc(SW, 4'h1, 3'h0, 32'hfffffffd, 1'b0);
      acc(SR, 4'h1, 3'h0, 32'h1, 1'b0);
      acc(NW, 4'h1, 3'h0, 32'h3, 1'b1);
      acc(UR, 4'h1, 3'h0, 32'h0, 1'b1);
      acc(UW, 4'h4, 3'h0, 32'h5, 1'b0);
      chk("access_ok", 32'h1, {31'h0, ok_w});
      acc(UW, 4'h2, 3'h0, 32'h1, 1'b0);
      chk("select", 32'h1, {31'h0, sel_w});
      acc(UW, 4'h4, 3'h0, 32'h5, 1'b1);
      chk("access_ok", 32'h0, {31'h0, ok_w});
      acc(SR, 4'h2, 3'h0, 32'h1, 1'b0);
      acc(SW, 4'h2, 3'h0, 32'h0, 1'b0);
      chk("select", 32'h0, {31'h0, sel_w});
      acc(SW, 4'h2, 3'h0, 32'h1, 1'b0);
      chk("select", 32'h1, {31'h0, sel_w});
      acc(SW, 4'h8, 3'h0, 32'h0, 1'b0);
      chk("access_ok", 32'h1, {31'h0, ok_w});
      @(posedge mclk);
      nsab <= 1'b1;
      acc(NR, 4'h0, 3'h0, 32'h3, 1'b0);
      acc(NR, 4'h1, 3'h0, 32'h1, 1'b0);
      acc(NUW, 4'h2, 3'h0, 32'h0, 1'b0);
      chk("select", 32'h0, {31'h0, sel_w});
      acc(NU, 4'h8, 3'h0, 32'h0, 1'b0);
      chk("access_ok", 32'h1, {31'h0, ok_w});
      acc(NU, 4'h1, 3'h0, 32'h0, 1'b1);
      @(posedge mclk);
      nsab <= 1'b0;
      acc(NW, 4'h4, 3'h0, 32'h0, 1'b1);
      chk("access_ok", 32'h0, {31'h0, ok_w});
      acc(NUW, 4'h2, 3'h0, 32'h1, 1'b1);
      @(posedge mclk);
      req <= '{1'b1, 1'b0, 1'b0, 1'b0, 4'ha, 4'h0, 3'h0, 32'h0};
      @(posedge mclk);
      req.valid <= 1'b0;
      #1;
      chk("other_crn", 32'h0, {30'h0, rsp.undef, rsp.done});
      $display("test permits done");
      summarize;
   end
endmodule // pcu_bank_tb

// *** verif/pcu_engine_model.sv ***
// engine model: registered channel running and interrupt levels
// assumes the bench sets the wanted levels on mclk
`timescale 1ns/10ps
module pcu_engine_model (
   // clock, wanted levels and levels out as {interrupt, running}
   input  wire logic       mclk,
   input  wire logic [3:0] lvl_set,
   output logic [3:0]      lvl
);
   always_ff @(posedge mclk) lvl <= lvl_set;
endmodule // pcu_engine_model
